// ===== hdl/burst_master_pkg.sv
// Purpose: constants for the five-channel burst bus master
// Assumes: one clock, synchronous active-low reset
// Notes: widths fixed; burst length counts beats minus one
package burst_master_pkg;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int LEN_W = 8;
  localparam int RESP_W = 2;
  localparam logic [LEN_W-1:0] LEN_ZERO = 8'h00;
  localparam logic [LEN_W-1:0] LEN_ONE = 8'h01;
  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h00000000;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 32'h00000000;
  localparam logic [RESP_W-1:0] RESP_ZERO = 2'h0;
endpackage : burst_master_pkg

// ===== hdl/burst_master.sv
// Purpose: bus master driving five valid/ready channels from user commands
// Assumes: user holds command fields while its request is high
// Notes: one write and one read outstanding at a time
`timescale 1ns/1ps
module burst_master
  import burst_master_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  // User write command
  input wire logic wrReq,
  input wire logic [ADDR_W-1:0] wrAddr,
  input wire logic [LEN_W-1:0] wrLen,
  output logic wrBusy,
  // User write data, one beat per wrDataTake pulse
  input wire logic [DATA_W-1:0] wrData,
  output logic wrDataTake,
  output logic wrDone,
  output logic [RESP_W-1:0] wrResp,
  // User read command
  input wire logic rdReq,
  input wire logic [ADDR_W-1:0] rdAddr,
  input wire logic [LEN_W-1:0] rdLen,
  output logic rdBusy,
  output logic rdBeatValid,
  output logic [DATA_W-1:0] rdBeatData,
  output logic rdBeatLast,
  output logic [RESP_W-1:0] rdBeatResp,
  // Write address channel
  output logic awValid,
  input wire logic awReady,
  output logic [ADDR_W-1:0] awAddr,
  output logic [LEN_W-1:0] awLen,
  // Write data channel
  output logic wValid,
  input wire logic wReady,
  output logic [DATA_W-1:0] wData,
  output logic wLast,
  // Write response channel
  input wire logic bValid,
  output logic bReady,
  input wire logic [RESP_W-1:0] bResp,
  // Read address channel
  output logic arValid,
  input wire logic arReady,
  output logic [ADDR_W-1:0] arAddr,
  output logic [LEN_W-1:0] arLen,
  // Read data channel
  input wire logic rValid,
  output logic rReady,
  input wire logic [DATA_W-1:0] rData,
  input wire logic rLast,
  input wire logic [RESP_W-1:0] rResp
);
  // Two independent engines; reads never wait for writes
  typedef enum logic [1:0] {W_IDLE, W_RUN, W_RESP} wr_state_type;
  typedef enum logic [1:0] {R_IDLE, R_ADDR, R_DATA} rd_state_type;

  wr_state_type wrState_r, wrState_nxt;
  rd_state_type rdState_r, rdState_nxt;
  logic awValid_r, awValid_nxt;
  logic [ADDR_W-1:0] awAddr_r, awAddr_nxt;
  logic [LEN_W-1:0] awLen_r, awLen_nxt;
  logic wValid_r, wValid_nxt;
  logic [DATA_W-1:0] wData_r, wData_nxt;
  logic wLast_r, wLast_nxt;
  // Beats still to load after the one on the bus
  logic [LEN_W-1:0] beatsLeft_r, beatsLeft_nxt;
  logic wrDataTake_r, wrDataTake_nxt;
  logic wrDone_r, wrDone_nxt;
  logic [RESP_W-1:0] wrResp_r, wrResp_nxt;
  logic arValid_r, arValid_nxt;
  logic [ADDR_W-1:0] arAddr_r, arAddr_nxt;
  logic [LEN_W-1:0] arLen_r, arLen_nxt;
  logic rdBeatValid_r, rdBeatValid_nxt;
  logic [DATA_W-1:0] rdBeatData_r, rdBeatData_nxt;
  logic rdBeatLast_r, rdBeatLast_nxt;
  logic [RESP_W-1:0] rdBeatResp_r, rdBeatResp_nxt;
  logic awFire, wFire, bFire, arFire, rFire;

  // Valid, address and data outputs are flops and readies decode state, so no input reaches an output directly
  assign awValid = awValid_r;
  assign awAddr = awAddr_r;
  assign awLen = awLen_r;
  assign wValid = wValid_r;
  assign wData = wData_r;
  assign wLast = wLast_r;
  assign arValid = arValid_r;
  assign arAddr = arAddr_r;
  assign arLen = arLen_r;
  // Ready tied to state, never to the slave's valid
  assign bReady = (wrState_r == W_RESP);
  assign rReady = (rdState_r == R_DATA);
  assign wrBusy = (wrState_r != W_IDLE);
  assign rdBusy = (rdState_r != R_IDLE);
  assign wrDataTake = wrDataTake_r;
  assign wrDone = wrDone_r;
  assign wrResp = wrResp_r;
  assign rdBeatValid = rdBeatValid_r;
  assign rdBeatData = rdBeatData_r;
  assign rdBeatLast = rdBeatLast_r;
  assign rdBeatResp = rdBeatResp_r;

  // Transfer only when both sides are high at the edge
  assign awFire = awValid_r & awReady;
  assign wFire = wValid_r & wReady;
  assign bFire = bValid & bReady;
  assign arFire = arValid_r & arReady;
  assign rFire = rValid & rReady;

  // Write path: address, data beats, then response
  always_comb
  begin
    wrState_nxt = wrState_r;
    awValid_nxt = awValid_r;
    awAddr_nxt = awAddr_r;
    awLen_nxt = awLen_r;
    wValid_nxt = wValid_r;
    wData_nxt = wData_r;
    wLast_nxt = wLast_r;
    beatsLeft_nxt = beatsLeft_r;
    wrDataTake_nxt = 1'b0;
    wrDone_nxt = 1'b0;
    wrResp_nxt = wrResp_r;
    if (awFire)
    begin
      awValid_nxt = 1'b0;
    end
    if (wFire)
    begin
      wValid_nxt = 1'b0;
    end
    unique case (wrState_r)
      W_IDLE:
      begin
        if (wrReq)
        begin
          // Address and first beat raised together, blind to ready
          awValid_nxt = 1'b1;
          awAddr_nxt = wrAddr;
          awLen_nxt = wrLen;
          wValid_nxt = 1'b1;
          wData_nxt = wrData;
          wLast_nxt = (wrLen == LEN_ZERO);
          beatsLeft_nxt = wrLen;
          wrDataTake_nxt = 1'b1;
          wrState_nxt = W_RUN;
        end
      end
      W_RUN:
      begin
        if (wFire && !wLast_r)
        begin
          // Next beat follows straight after the last one moved
          wValid_nxt = 1'b1;
          wData_nxt = wrData;
          wLast_nxt = (beatsLeft_r == LEN_ONE);
          beatsLeft_nxt = beatsLeft_r - LEN_ONE;
          wrDataTake_nxt = 1'b1;
        end
        // Response waits for both address and last beat to have moved
        if ((wFire && wLast_r) || !wValid_r)
        begin
          if (!awValid_r || awFire)
          begin
            wrState_nxt = W_RESP;
          end
        end
      end
      W_RESP:
      begin
        // Ready only here, so it is never high by default
        if (bFire)
        begin
          wrResp_nxt = bResp;
          wrDone_nxt = 1'b1;
          wrState_nxt = W_IDLE;
        end
      end
      default:
      begin
        wrState_nxt = W_IDLE;
      end
    endcase
  end

  // Write registers
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      // Valids forced low throughout reset
      wrState_r <= W_IDLE;
      awValid_r <= 1'b0;
      awAddr_r <= ADDR_ZERO;
      awLen_r <= LEN_ZERO;
      wValid_r <= 1'b0;
      wData_r <= DATA_ZERO;
      wLast_r <= 1'b0;
      beatsLeft_r <= LEN_ZERO;
      wrDataTake_r <= 1'b0;
      wrDone_r <= 1'b0;
      wrResp_r <= RESP_ZERO;
    end
    else
    begin
      wrState_r <= wrState_nxt;
      awValid_r <= awValid_nxt;
      awAddr_r <= awAddr_nxt;
      awLen_r <= awLen_nxt;
      wValid_r <= wValid_nxt;
      wData_r <= wData_nxt;
      wLast_r <= wLast_nxt;
      beatsLeft_r <= beatsLeft_nxt;
      wrDataTake_r <= wrDataTake_nxt;
      wrDone_r <= wrDone_nxt;
      wrResp_r <= wrResp_nxt;
    end
  end

  // Read path: address, then beats until the last marker
  always_comb
  begin
    rdState_nxt = rdState_r;
    arValid_nxt = arValid_r;
    arAddr_nxt = arAddr_r;
    arLen_nxt = arLen_r;
    rdBeatValid_nxt = 1'b0;
    rdBeatData_nxt = rdBeatData_r;
    rdBeatLast_nxt = rdBeatLast_r;
    rdBeatResp_nxt = rdBeatResp_r;
    unique case (rdState_r)
      R_IDLE:
      begin
        // One read at a time keeps data ordering trivial
        if (rdReq)
        begin
          arValid_nxt = 1'b1;
          arAddr_nxt = rdAddr;
          arLen_nxt = rdLen;
          rdState_nxt = R_ADDR;
        end
      end
      R_ADDR:
      begin
        // Read ready stays low until the address has moved
        if (arFire)
        begin
          arValid_nxt = 1'b0;
          rdState_nxt = R_DATA;
        end
      end
      R_DATA:
      begin
        if (rFire)
        begin
          // Burst ends on the slave's last marker, not on a count
          rdBeatValid_nxt = 1'b1;
          rdBeatData_nxt = rData;
          rdBeatLast_nxt = rLast;
          rdBeatResp_nxt = rResp;
          if (rLast)
          begin
            rdState_nxt = R_IDLE;
          end
        end
      end
      default:
      begin
        rdState_nxt = R_IDLE;
      end
    endcase
  end

  // Read registers
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      rdState_r <= R_IDLE;
      arValid_r <= 1'b0;
      arAddr_r <= ADDR_ZERO;
      arLen_r <= LEN_ZERO;
      rdBeatValid_r <= 1'b0;
      rdBeatData_r <= DATA_ZERO;
      rdBeatLast_r <= 1'b0;
      rdBeatResp_r <= RESP_ZERO;
    end
    else
    begin
      rdState_r <= rdState_nxt;
      arValid_r <= arValid_nxt;
      arAddr_r <= arAddr_nxt;
      arLen_r <= arLen_nxt;
      rdBeatValid_r <= rdBeatValid_nxt;
      rdBeatData_r <= rdBeatData_nxt;
      rdBeatLast_r <= rdBeatLast_nxt;
      rdBeatResp_r <= rdBeatResp_nxt;
    end
  end
endmodule : burst_master

// ===== verification/burst_master_monitor.sv
// Purpose: bus-side and user-side protocol checks on burst_master
// Assumes: one clock, synchronous active-low reset
// Notes: bound to every burst_master instance
`timescale 1ns/1ps
module burst_master_monitor
  import burst_master_pkg::*;
(
  input logic ref_clk,
  input logic reset_n,
  input logic wrReq,
  input logic wrBusy,
  input logic wrDone,
  input logic rdBeatValid,
  input logic [DATA_W-1:0] rdBeatData,
  input logic rdBeatLast,
  input logic awValid,
  input logic awReady,
  input logic [ADDR_W-1:0] awAddr,
  input logic wValid,
  input logic wReady,
  input logic [DATA_W-1:0] wData,
  input logic wLast,
  input logic bValid,
  input logic bReady,
  input logic arValid,
  input logic arReady,
  input logic [ADDR_W-1:0] arAddr,
  input logic rValid,
  input logic rReady,
  input logic [DATA_W-1:0] rData,
  input logic rLast
);
  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  AST_AW_HOLD: assert property (
    awValid && !awReady |=> awValid && $stable(awAddr))
    else $error("aw item not held");
  AST_W_HOLD: assert property (
    wValid && !wReady |=> wValid && $stable({wData, wLast}))
    else $error("w item not held");
  AST_AR_HOLD: assert property (
    arValid && !arReady |=> arValid && $stable(arAddr))
    else $error("ar item not held");
  AST_RST_VALID: assert property (
    disable iff (1'b0) !reset_n |=> !awValid && !wValid && !arValid)
    else $error("valid high in reset");
  AST_B_DONE: assert property (
    bValid && bReady |=> wrDone && !bReady)
    else $error("response not taken");
  AST_B_AFTER_W: assert property (
    bReady |-> !awValid && !wValid)
    else $error("response ready before write sent");
  AST_R_BEAT: assert property (
    rValid && rReady |=> rdBeatValid && rdBeatData == $past(rData))
    else $error("read beat lost");
  AST_R_LAST: assert property (
    rValid && rReady && rLast |=> !rReady && rdBeatLast)
    else $error("last beat not ended");
  AST_R_AFTER_AR: assert property (
    arValid |-> !rReady)
    else $error("read ready before address");
  AST_W_START: assert property (
    wrReq && !wrBusy |=> awValid && wValid)
    else $error("valid waited");
endmodule : burst_master_monitor
bind burst_master burst_master_monitor i_burst_master_monitor (.*);

// ===== verification/burst_slave_model.sv
// Purpose: behavioural far-side slave for burst_master
// Assumes: one write and one read outstanding
// Notes: stall[0] holds address readies low, stall[1] data
`timescale 1ns/1ps
module burst_slave_model
  import burst_master_pkg::*;
(
  input logic ref_clk,
  input logic reset_n,
  input logic [1:0] stall,
  input logic awValid,
  output logic awReady,
  input logic [LEN_W-1:0] awLen,
  input logic wValid,
  output logic wReady,
  input logic wLast,
  output logic bValid,
  input logic bReady,
  output logic [RESP_W-1:0] bResp,
  input logic arValid,
  output logic arReady,
  input logic [ADDR_W-1:0] arAddr,
  input logic [LEN_W-1:0] arLen,
  output logic rValid,
  input logic rReady,
  output logic [DATA_W-1:0] rData,
  output logic rLast
);
  logic awSeen, wSeen, rBusy;
  logic [LEN_W-1:0] rCnt, rLen;
  logic [RESP_W-1:0] resp;
  logic [ADDR_W-1:0] rBase;
  assign awReady = !stall[0];
  assign arReady = !stall[0] && !rBusy;
  assign wReady = !stall[1];
  // Idle lines invert, so stale values never pass
  assign bResp = resp ^ {RESP_W{!bValid}};
  assign rData = (rBase + rCnt) ^ {DATA_W{!rValid}};
  assign rLast = (rCnt == rLen) ~^ rValid;
  always_ff @(posedge ref_clk)
    if (!reset_n)
      {bValid, rValid, awSeen, wSeen, rBusy, rCnt, rLen, resp, rBase} <= '0;
    else
    begin
      if (awValid && awReady)
        {awSeen, resp} <= {1'b1, awLen[1:0]};
      if (wValid && wReady && wLast)
        wSeen <= 1'b1;
      if (awSeen && wSeen && !bValid)
        {bValid, awSeen, wSeen} <= 3'h4;
      else if (bValid && bReady)
        bValid <= 1'b0;
      if (arValid && arReady)
        {rBusy, rBase, rLen, rCnt} <= {1'b1, arAddr, arLen, LEN_ZERO};
      if (rValid && rReady)
      begin
        rCnt <= rCnt + LEN_ONE;
        rValid <= !rLast && !stall[1];
        rBusy <= !rLast;
      end
      else if (rBusy && !stall[1])
        rValid <= 1'b1;
    end
endmodule : burst_slave_model

// ===== verification/burst_master_bench.sv
// Purpose: self-checking bench for burst_master
// Assumes: slave model answers on the bus side
// Notes: stall pattern picks which channels wait
`timescale 1ns/1ps
module burst_master_bench;
  import burst_master_pkg::*;
  logic ref_clk = 1'b0, reset_n = 1'b0, wrReq = 1'b0, rdReq = 1'b0;
  logic wrBusy, wrDataTake, wrDone, rdBusy, rdBeatValid, rdBeatLast;
  logic awValid, awReady, wValid, wReady, wLast, bValid, bReady;
  logic arValid, arReady, rValid, rReady, rLast;
  logic [1:0] stall = 2'h0;
  logic [RESP_W-1:0] wrResp, rdBeatResp, bResp, rResp = RESP_ZERO;
  logic [DATA_W-1:0] wrData = 32'h10, expW = 32'h10, rdBeatData, wData, rData;
  logic [ADDR_W-1:0] wrAddr = ADDR_ZERO, rdAddr = ADDR_ZERO, awAddr, arAddr;
  logic [LEN_W-1:0] wrLen = LEN_ZERO, rdLen = LEN_ZERO, awLen, arLen, curLen;
  int n_mismatch = 0, n_compared = 0, wBeat, rBeat, nTake;
  burst_master i_burst_master (.*);
  burst_slave_model i_burst_slave_model (.*);
  always #4 ref_clk = ~ref_clk;
  task automatic check(input string what, input logic [DATA_W-1:0] exp, got);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict
  // Next beat must already stand in the take cycle
  always @(posedge ref_clk)
    if ((wrReq && !wrBusy) || (wValid && wReady && !wLast))
      wrData <= wrData + 32'h1;
  always @(posedge ref_clk)
    if (reset_n)
    begin
      if (wrDataTake === 1'b1)
        nTake++;
      if (wValid && wReady)
      begin
        check("wData", expW, wData);
        check("wLast", wBeat == curLen, wLast);
        expW = expW + 32'h1;
        wBeat++;
      end
      if (rdBeatValid)
      begin
        check("rdBeatData", rdAddr + rBeat, rdBeatData);
        check("rdBeatLast", rBeat == curLen, rdBeatLast);
        check("rdBeatResp", rdLen[1:0], rdBeatResp);
        rBeat++;
      end
    end
  task automatic do_write(input logic [LEN_W-1:0] len, input logic [1:0] st);
    int n;
    @(posedge ref_clk);
    {wrLen, wrAddr, stall, wrReq} <= {len, 32'h200, st, 1'b1};
    wBeat = 0;
    nTake = 0;
    curLen = len;
    @(posedge ref_clk);
    wrReq <= 1'b0;
    for (n = 0; n < 600 && wrDone !== 1'b1; n++)
      @(posedge ref_clk) stall <= (n < 6) ? st : 2'h0;
    @(posedge ref_clk);
    check("wrTimeout", 32'h0, n >= 600);
    check("wrResp", len[1:0], wrResp);
    check("wBeats", len + LEN_ONE, wBeat);
    check("wTakes", len + LEN_ONE, nTake);
    check("wrBusy", 32'h0, wrBusy);
    $display("write test len %0d done", len);
  endtask : do_write
  task automatic do_read(input logic [LEN_W-1:0] len, input logic [1:0] st);
    int n;
    @(posedge ref_clk);
    {rdLen, rdAddr, stall, rdReq} <= {len, 32'h1000 + len, st, 1'b1};
    rResp <= len[1:0];
    rBeat = 0;
    curLen = len;
    @(posedge ref_clk);
    rdReq <= 1'b0;
    for (n = 0; n < 600 && !(rdBeatValid === 1'b1 && rdBeatLast === 1'b1);
         n++)
      @(posedge ref_clk) stall <= (n < 6) ? st : 2'h0;
    @(posedge ref_clk);
    check("rdTimeout", 32'h0, n >= 600);
    check("rBeats", len + LEN_ONE, rBeat);
    check("rdBusy", 32'h0, rdBusy);
    $display("read test len %0d done", len);
  endtask : do_read
  initial
  begin
    repeat (10) @(posedge ref_clk);
    reset_n <= 1'b1;
    do_write(8'h00, 2'h0);
    do_write(8'h03, 2'h1);
    do_write(8'h02, 2'h2);
    do_read(8'h00, 2'h0);
    do_read(8'h03, 2'h3);
    print_verdict();
  end
  // Tests need under a hundred cycles; this limit is 5000 cycles
  initial
  begin
    #40000;
    n_mismatch++;
    print_verdict();
  end
endmodule : burst_master_bench
